// >>> fsf_map.svh
// Register offsets, field positions and reset values of the FIFO flag block
`ifndef FSF_MAP_SVH
`define FSF_MAP_SVH
`define FSF_OFF_STATUS 8'h0B
`define FSF_OFF_SETUP 8'h28
`define FSF_OFF_THRESH 8'h29
`define FSF_OFF_MAP1 8'h2A
`define FSF_OFF_MAP2 8'h2B
`define FSF_BIT_READY 1
`define FSF_BIT_LEVEL 2
`define FSF_BIT_OVERRUN 3
`define FSF_BIT_THR_HIGH 3
`define FSF_BIT_INT_LOW 7
`define FSF_MODE_LSB 0
`define FSF_MODE_MSB 1
`define FSF_RST_SETUP 8'h00
`define FSF_RST_THRESH 8'h80
`define FSF_RST_MAP 8'h00
`define FSF_DEPTH 512
`endif

// >>> fsf_pkg.sv
// Types shared by the FIFO flag block
`default_nettype none
package fsf_pkg;
	typedef enum logic [1:0] {
		FSF_MODE_OFF = 2'b00,
		FSF_MODE_OLDEST = 2'b01,
		FSF_MODE_STREAM = 2'b10,
		FSF_MODE_TRIGGER = 2'b11
	} fsf_mode_t;
	// Flags in the same bit order as status bits 3..1
	typedef struct packed {
		logic overrun;
		logic level;
		logic ready;
	} fsf_flags_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fsf_reg_req_t;
endpackage : fsf_pkg
`default_nettype wire

// >>> fsf_pin_drive.sv
// Drive of one interrupt pin from its flag map
`timescale 1ns/1ps
`default_nettype none
`include "fsf_map.svh"
module fsf_pin_drive import fsf_pkg::*; (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] map_i,
	input wire fsf_flags_t flags_i,
	output logic pin_o,
	output logic pin_oe_o
);
	logic active;
	assign active = |(map_i[`FSF_BIT_OVERRUN:`FSF_BIT_READY] & flags_i);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_oe_o <= 1'b0;
		end else begin
			pin_oe_o <= |map_i[`FSF_BIT_INT_LOW-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_o <= 1'b0;
		end else begin
			pin_o <= active ^ map_i[`FSF_BIT_INT_LOW];
		end
	end

	property p_pin_polarity;
		@(posedge clk_i) disable iff (!arst_n_i)
		pin_oe_o |-> (pin_o == ($past(active) ^ $past(map_i[`FSF_BIT_INT_LOW])));
	endproperty
	a_pin_polarity: assert property (p_pin_polarity) else $error("pin level not flag OR with polarity");

	property p_pin_hiz;
		@(posedge clk_i) disable iff (!arst_n_i)
		(map_i[`FSF_BIT_INT_LOW-1:0] == 7'h00) |=> !pin_oe_o;
	endproperty
	a_pin_hiz: assert property (p_pin_hiz) else $error("unmapped pin is driven");
endmodule : fsf_pin_drive
`default_nettype wire

// >>> fsf_flag_logic.sv
// FIFO status flags, setup registers and interrupt pin routing
// Overview of operation
// - Level flag, status bit 2, set when stored count reaches the threshold.
// - Level flag clears itself once reads drop the count below threshold.
// - A zero threshold keeps the level flag asserted.
// - Threshold count register resets to 0x80.
// - Non-empty flag high whenever the FIFO holds a valid sample.
// - Non-empty flag maps to pins through bit 1 of both map registers.
// - Overflow flag, status bit 3, set when unread data is overwritten.
// - In oldest-saved mode overflow sets when a sample finds no room.
// - Reading the FIFO clears the overflow flag without any acknowledge.
// - Disabling the FIFO clears the overflow flag.
// - Pin is OR of its mapped flags; unmapped or after reset, high-Z.
// - Pins active high unless the map register low-polarity bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "fsf_map.svh"
module fsf_flag_logic import fsf_pkg::*; #(
	parameter int DEPTH = `FSF_DEPTH
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire fsf_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	input wire logic sample_push_i,
	input wire logic sample_pop_i,
	output logic [$clog2(DEPTH+1)-1:0] fifo_count_o,
	output logic interrupt_pin_one_o,
	output logic interrupt_pin_one_oe_o,
	output logic interrupt_pin_two_o,
	output logic interrupt_pin_two_oe_o
);
	localparam int CNT_W = $clog2(DEPTH+1);
	// Compare width covers both the count and the nine-bit threshold so neither is cut
	localparam int CMP_W = (CNT_W > 9) ? CNT_W : 9;

	logic [7:0] fifo_setup;
	logic [7:0] fifo_threshold_count;
	logic [7:0] pin_one_flag_map;
	logic [7:0] pin_two_flag_map;
	logic [CNT_W-1:0] count;
	logic overrun;
	logic next_overrun;
	logic [CNT_W-1:0] next_count;
	logic [8:0] threshold;
	logic [CMP_W-1:0] count_ext;
	logic [CMP_W-1:0] threshold_ext;
	logic full;
	logic enabled;
	logic ov_set;
	logic ov_clear;
	fsf_mode_t mode;
	fsf_flags_t flags;
	logic [7:0] status;

	assign mode = fsf_mode_t'(fifo_setup[`FSF_MODE_MSB:`FSF_MODE_LSB]);
	assign enabled = (mode != FSF_MODE_OFF);
	assign threshold = {fifo_setup[`FSF_BIT_THR_HIGH], fifo_threshold_count};
	assign count_ext = CMP_W'(count);
	assign threshold_ext = CMP_W'(threshold);
	assign full = (count == CNT_W'(DEPTH));
	assign fifo_count_o = count;

	// Register writes
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fifo_setup <= `FSF_RST_SETUP;
			fifo_threshold_count <= `FSF_RST_THRESH;
			pin_one_flag_map <= `FSF_RST_MAP;
			pin_two_flag_map <= `FSF_RST_MAP;
		end else if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				`FSF_OFF_SETUP: fifo_setup <= reg_req_i.wdata;
				`FSF_OFF_THRESH: fifo_threshold_count <= reg_req_i.wdata;
				`FSF_OFF_MAP1: pin_one_flag_map <= reg_req_i.wdata;
				`FSF_OFF_MAP2: pin_two_flag_map <= reg_req_i.wdata;
				default: ;
			endcase
		end
	end

	// Occupancy: a full FIFO keeps its count whether it overwrites or drops
	always_comb begin
		next_count = count;
		if (!enabled) begin
			next_count = '0;
		end else if (sample_push_i && !(sample_pop_i && count != '0)) begin
			if (!full) begin
				next_count = count + CNT_W'(1);
			end
		end else if (sample_pop_i && !sample_push_i && count != '0) begin
			next_count = count - CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Overflow: a same-cycle read blocks the set, so the clear by a read wins
	assign ov_set = enabled && sample_push_i && full && !sample_pop_i;
	assign ov_clear = sample_pop_i || !enabled;
	assign next_overrun = ov_set || (overrun && !ov_clear);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overrun <= 1'b0;
		end else begin
			overrun <= next_overrun;
		end
	end

	assign flags.ready = (count != '0);
	assign flags.level = (count_ext >= threshold_ext);
	assign flags.overrun = overrun;

	always_comb begin
		status = 8'h00;
		status[`FSF_BIT_OVERRUN:`FSF_BIT_READY] = flags;
	end

	// Read data
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				`FSF_OFF_STATUS: reg_rdata_o <= status;
				`FSF_OFF_SETUP: reg_rdata_o <= fifo_setup;
				`FSF_OFF_THRESH: reg_rdata_o <= fifo_threshold_count;
				`FSF_OFF_MAP1: reg_rdata_o <= pin_one_flag_map;
				`FSF_OFF_MAP2: reg_rdata_o <= pin_two_flag_map;
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	fsf_pin_drive u_pin_one (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.map_i(pin_one_flag_map),
		.flags_i(flags),
		.pin_o(interrupt_pin_one_o),
		.pin_oe_o(interrupt_pin_one_oe_o)
	);

	fsf_pin_drive u_pin_two (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.map_i(pin_two_flag_map),
		.flags_i(flags),
		.pin_o(interrupt_pin_two_o),
		.pin_oe_o(interrupt_pin_two_oe_o)
	);

	property p_level_set;
		@(posedge clk_i) disable iff (!arst_n_i)
		(count_ext >= CMP_W'({fifo_setup[`FSF_BIT_THR_HIGH], fifo_threshold_count})) |-> status[2];
	endproperty
	a_level_set: assert property (p_level_set) else $error("level flag low at threshold");

	property p_level_drain;
		@(posedge clk_i) disable iff (!arst_n_i)
		(sample_pop_i && !sample_push_i && threshold != 9'h000
			&& count_ext == threshold_ext && !reg_req_i.wr) |=> !flags.level;
	endproperty
	a_level_drain: assert property (p_level_drain) else $error("level flag held below threshold");

	property p_level_zero;
		@(posedge clk_i) disable iff (!arst_n_i)
		(threshold == 9'h000) |-> flags.level;
	endproperty
	a_level_zero: assert property (p_level_zero) else $error("zero threshold without level flag");

	property p_thresh_reset;
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(arst_n_i) |-> (fifo_threshold_count == `FSF_RST_THRESH);
	endproperty
	a_thresh_reset: assert property (p_thresh_reset) else $error("threshold reset value wrong");

	property p_ready;
		@(posedge clk_i) disable iff (!arst_n_i)
		enabled && sample_push_i |=> status[1];
	endproperty
	a_ready: assert property (p_ready) else $error("non-empty flag missing after push");

	property p_overwrite;
		@(posedge clk_i) disable iff (!arst_n_i)
		(mode == FSF_MODE_STREAM && full && sample_push_i && !sample_pop_i) |=> (status[3] && full);
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overwrite without overflow flag");

	property p_oldest_full;
		@(posedge clk_i) disable iff (!arst_n_i)
		(mode == FSF_MODE_OLDEST && full && sample_push_i && !sample_pop_i && !reg_req_i.wr)
			|=> (overrun && count == $past(count));
	endproperty
	a_oldest_full: assert property (p_oldest_full) else $error("dropped sample not flagged");

	property p_read_clear;
		@(posedge clk_i) disable iff (!arst_n_i)
		(overrun && sample_pop_i && !sample_push_i) |=> !overrun;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("overflow not cleared by read");

	property p_off_clear;
		@(posedge clk_i) disable iff (!arst_n_i)
		!enabled |=> (!overrun && count == '0);
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("overflow kept while disabled");
endmodule : fsf_flag_logic
`default_nettype wire

// >>> fsf_host_model.sv
// Host model that issues register accesses to the flag block
`timescale 1ns/1ps
`default_nettype none
module fsf_host_model import fsf_pkg::*; (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output var fsf_reg_req_t req_o
);
	initial req_o = '0;
	// One access: request held for one edge, read data taken a cycle later
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(negedge clk_i);
		req_o = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk_i);
		req_o = '0;
		q = rdata_i;
	endtask : acc
endmodule : fsf_host_model
`default_nettype wire

// >>> fifo_status_flag_logic_bench.sv
// Self-checking bench of the FIFO flag block
`timescale 1ns/1ps
`default_nettype none
module fifo_status_flag_logic_bench;
	import fsf_pkg::*;
	localparam int D = 8;
	logic clk_i = 0;
	logic arst_n_i = 0;
	logic push = 0;
	logic pop = 0;
	fsf_reg_req_t req;
	logic [7:0] rdata;
	logic [3:0] cnt_o;
	logic p1, e1, p2, e2, ovr;
	logic [1:0] mode;
	logic [7:0] q, s, m1, m2;
	logic [8:0] thr;
	int err_count = 0;
	int num_checks = 0;
	int cnt = 0;
	initial forever #5 clk_i = ~clk_i;
	fsf_flag_logic #(.DEPTH(D)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .sample_push_i(push), .sample_pop_i(pop), .fifo_count_o(cnt_o),
		.interrupt_pin_one_o(p1), .interrupt_pin_one_oe_o(e1),
		.interrupt_pin_two_o(p2), .interrupt_pin_two_oe_o(e2));
	fsf_host_model host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic pin_f(input logic [7:0] m, input logic [7:0] st);
		return (|(m[3:1] & st[3:1])) ^ m[7];
	endfunction : pin_f
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	// One FIFO event, then status, count and both pins compared with the model
	task automatic step(input logic p, input logic u);
		@(negedge clk_i);
		push = p;
		pop = u;
		@(negedge clk_i);
		push = 0;
		pop = 0;
		if (mode != 2'b00) begin
			if (u && cnt > 0) ovr = 0;
			if (p && u) cnt = (cnt == 0) ? 1 : cnt;
			else if (p && cnt == D) ovr = 1;
			else if (p) cnt++;
			else if (u && cnt > 0) cnt--;
		end
		s = {4'h0, ovr, cnt >= thr, cnt != 0, 1'b0};
		host.acc(0, 8'h0B, 8'h00, q);
		check(q, s);
		check({4'h0, cnt_o}, 8'(cnt));
		check({4'h0, e1, p1, e2, p2}, {4'h0, |m1[6:0], pin_f(m1, s), |m2[6:0], pin_f(m2, s)});
	endtask : step
	initial begin
		void'($urandom(13));
		mode = 0;
		ovr = 0;
		thr = 9'h080;
		m1 = 0;
		m2 = 0;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i) arst_n_i = 1;
		check({6'h00, e1, e2}, 8'h00);
		host.acc(0, 8'h29, 8'h00, q);
		check(q, 8'h80);
		host.acc(0, 8'h40, 8'h00, q);
		check(q, 8'h00);
		for (int t = 0; t < 4; t++) begin
			thr = (t == 0) ? 9'h000 : 9'($urandom_range(D, 1));
			if (t == 3) thr[8] = 1;
			m1 = (t == 2) ? 8'h00 : {t[0], 3'h0, 3'($urandom_range(7, 1)), 1'b0};
			m2 = {~t[0], 3'h0, 3'($urandom_range(7, 0)), 1'b0};
			mode = (t == 3) ? 2'b11 : (t[1] ? 2'b10 : 2'b01);
			host.acc(1, 8'h28, {4'h0, thr[8], 1'b0, mode}, q);
			host.acc(1, 8'h29, thr[7:0], q);
			host.acc(1, 8'h2A, m1, q);
			host.acc(1, 8'h2B, m2, q);
			host.acc(0, 8'h28, 8'h00, q);
			check(q, {4'h0, thr[8], 1'b0, mode});
			host.acc(0, 8'h2A, 8'h00, q);
			check(q, m1);
			host.acc(0, 8'h2B, 8'h00, q);
			check(q, m2);
			for (int i = 0; i < 40; i++)
				step($urandom_range(9, 0) < (i < 20 ? 8 : 2), $urandom_range(9, 0) < (i < 20 ? 2 : 8));
			for (int i = 0; i < D + 2; i++) step(1, 0);
			step(0, 1);
			host.acc(1, 8'h28, 8'h00, q);
			mode = 0;
			cnt = 0;
			ovr = 0;
			step(0, 0);
			$display("test %0d done", t);
		end
		finish_test();
	end
endmodule : fifo_status_flag_logic_bench
`default_nettype wire
